// ### hdl/acs_pkg.sv
// package for the conversion sequencer: register map, field positions,
// reset values, bus and analog carrier structs, sequencer states.
// assumes an AXI4-Lite master with 32-bit data on the register side.
package acs_pkg;

   // register byte offsets
   localparam logic [4:0] ACS_OFF_CTRL0 = 5'h00;
   localparam logic [4:0] ACS_OFF_CTRL1 = 5'h04;
   localparam logic [4:0] ACS_OFF_RES_HI = 5'h08;
   localparam logic [4:0] ACS_OFF_RES_LO = 5'h0C;
   localparam logic [4:0] ACS_OFF_IRQ_STAT = 5'h10;
   localparam logic [4:0] ACS_OFF_IRQ_CLR = 5'h14;
   localparam logic [4:0] ACS_OFF_IRQ_EN = 5'h18;

   // field positions
   localparam int ACS_BIT_START = 0;
   localparam int ACS_BIT_POWER = 1;
   localparam int ACS_BIT_BUSY = 7;
   localparam int ACS_BIT_DONE = 0;

   // reset values
   localparam logic [2:0] ACS_RST_DIV_SEL = 3'h0;
   localparam logic [11:0] ACS_RST_RESULT = 12'h000;

   // sequence lengths in conversion clock periods, and the msb trial code
   localparam logic [1:0] ACS_SAMPLE_LAST = 2'h3;   // four periods
   localparam logic [3:0] ACS_CONV_FIRST = 4'hB;    // twelve bits, msb first
   localparam logic [11:0] ACS_MSB_TRIAL = 12'h800;
   localparam logic [4:0] ACS_TOTAL_LAST = 5'h0F;   // sixteen periods

   // bus responses
   localparam logic [1:0] ACS_RESP_OKAY = 2'h0;
   localparam logic [1:0] ACS_RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      ACS_IDLE,
      ACS_SAMPLE,
      ACS_CONVERT
   } acs_state_e;

   // master to slave
   typedef struct packed {
      logic awvalid;
      logic [31:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [31:0] araddr;
      logic rready;
   } acs_axi_req_s;

   // slave to master
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } acs_axi_rsp_s;

   // toward the analog core
   typedef struct packed {
      logic power_on;
      logic sample_hold;
      logic convert;
      logic [11:0] trial;
   } acs_ana_s;

endpackage : acs_pkg

// ### hdl/acs_clk_div.sv
// conversion clock divider: one-cycle tick every 2**sel system clocks.
// assumes clear is held while the sequencer is idle so a run starts on
// a full period.
`timescale 1ns/1ps

module acs_clk_div (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clear,
   input wire logic [2:0] sel,
   output logic tick
);

   typedef struct packed {
      logic [6:0] cnt;
   } acs_div_s;

   acs_div_s st;
   acs_div_s next_st;
   logic [6:0] mask;

   // mask of low counter bits; all ones ends a period, sel 0 ticks always
   always_comb begin
      mask = 7'((8'h01 << sel) - 8'h01);
      tick = !clear && ((st.cnt & mask) == mask);
      next_st = st;
      next_st.cnt = clear ? 7'h00 : 7'(st.cnt + 7'h01);
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

endmodule : acs_clk_div

// ### hdl/acs_seq.sv
// conversion sequencer: register file on AXI4-Lite, start pulse
// handling, sample and successive-approximation phases, done interrupt.
// assumes the analog core answers each trial code on cmp_in (high when
// the held input is at or above the trial) and settles between ticks.
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

// Operation
// - start bit low-high-low launches one conversion
// - busy flag set once conversion launches
// - busy flag cleared when conversion finishes
// - completion sets request flag, enabled raises interrupt
// - conversion clock is system clock over 2**select
// - converter powered only while power enable set
// - sampling lasts exactly four conversion periods
// - twelve conversion periods, sixteen in total
// - conversion runs without stalling the processor
// - result readable in high and low bytes
// - result is twelve bits, full scale all ones
module acs_seq (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire acs_pkg::acs_axi_req_s axi_req,
   output acs_pkg::acs_axi_rsp_s axi_rsp,
   input wire logic cmp_in,
   output acs_pkg::acs_ana_s ana,
   output logic irq
);

   typedef struct packed {
      logic aw_got;
      logic [31:0] aw_addr;
      logic w_got;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic start;
      logic start_q;
      logic power;
      logic [2:0] div_sel;
      logic irq_status;
      logic irq_enable;
      logic busy;
      acs_pkg::acs_state_e state;
      logic [1:0] samp_cnt;
      logic [3:0] bit_idx;
      logic [11:0] trial;
      logic [11:0] result;
      logic cmp_s1;
      logic cmp_s2;
      logic cmp_s3;
      logic cmp_val;
      logic [4:0] tick_cnt;
   } acs_seq_s;

   acs_seq_s st;
   acs_seq_s next_st;
   logic tick;
   logic div_clear;
   logic launch;
   logic done;
   logic do_write;
   logic done_clr;
   logic [11:0] bit_mask;
   logic [11:0] decided;
   logic [31:0] rd_word;
   logic rd_ok;
   logic wr_ok;

   // divider is held cleared outside a run so the first period is whole
   assign div_clear = (st.state == acs_pkg::ACS_IDLE);

   acs_clk_div u_div (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .clear(div_clear),
      .sel(st.div_sel),
      .tick(tick)
   );

   // read decode, unmapped or unaligned answers slverr
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_ok = (axi_req.araddr[31:5] == 27'h0) && (axi_req.araddr[1:0] == 2'h0);
      case (axi_req.araddr[4:0])
         acs_pkg::ACS_OFF_CTRL0: begin
            rd_word[acs_pkg::ACS_BIT_START] = st.start;
            rd_word[acs_pkg::ACS_BIT_POWER] = st.power;
            rd_word[acs_pkg::ACS_BIT_BUSY] = st.busy;
         end
         acs_pkg::ACS_OFF_CTRL1: rd_word[2:0] = st.div_sel;
         acs_pkg::ACS_OFF_RES_HI: rd_word[3:0] = st.result[11:8];
         acs_pkg::ACS_OFF_RES_LO: rd_word[7:0] = st.result[7:0];
         acs_pkg::ACS_OFF_IRQ_STAT: rd_word[0] = st.irq_status;
         acs_pkg::ACS_OFF_IRQ_CLR: rd_word = 32'h0000_0000;
         acs_pkg::ACS_OFF_IRQ_EN: rd_word[0] = st.irq_enable;
         default: rd_ok = 1'b0;
      endcase
   end

   // main next-state process: bus slave, registers, sequencer
   always_comb begin
      next_st = st;
      launch = 1'b0;
      done = 1'b0;
      done_clr = 1'b0;
      bit_mask = 12'(12'h001 << st.bit_idx);
      // comparator rejects the trial bit when low
      decided = st.cmp_val ? st.trial : (st.trial & ~bit_mask);
      wr_ok = (st.aw_addr[31:5] == 27'h0) && (st.aw_addr[1:0] == 2'h0);
      do_write = st.aw_got && st.w_got && !st.bvalid;

      // three-stage synchroniser, change taken once stages two and three agree
      next_st.cmp_s1 = cmp_in;
      next_st.cmp_s2 = st.cmp_s1;
      next_st.cmp_s3 = st.cmp_s2;
      if (st.cmp_s2 == st.cmp_s3) begin
         next_st.cmp_val = st.cmp_s3;
      end

      // address and data are taken independently, in either order
      if (axi_rsp.awready && axi_req.awvalid) begin
         next_st.aw_got = 1'b1;
         next_st.aw_addr = axi_req.awaddr;
      end
      if (axi_rsp.wready && axi_req.wvalid) begin
         next_st.w_got = 1'b1;
         next_st.wdata = axi_req.wdata;
         next_st.wstrb = axi_req.wstrb;
      end
      if (st.bvalid && axi_req.bready) begin
         next_st.bvalid = 1'b0;
      end
      if (do_write) begin
         next_st.aw_got = 1'b0;
         next_st.w_got = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = acs_pkg::ACS_RESP_OKAY;
         case (st.aw_addr[4:0])
            acs_pkg::ACS_OFF_CTRL0: begin
               if (st.wstrb[0]) begin
                  next_st.start = st.wdata[acs_pkg::ACS_BIT_START];
                  next_st.power = st.wdata[acs_pkg::ACS_BIT_POWER];
               end
            end
            acs_pkg::ACS_OFF_CTRL1: begin
               if (st.wstrb[0]) begin
                  next_st.div_sel = st.wdata[2:0];
               end
            end
            acs_pkg::ACS_OFF_IRQ_CLR: begin
               done_clr = st.wstrb[0] && st.wdata[acs_pkg::ACS_BIT_DONE];
            end
            acs_pkg::ACS_OFF_IRQ_EN: begin
               if (st.wstrb[0]) begin
                  next_st.irq_enable = st.wdata[acs_pkg::ACS_BIT_DONE];
               end
            end
            acs_pkg::ACS_OFF_RES_HI, acs_pkg::ACS_OFF_RES_LO,
            acs_pkg::ACS_OFF_IRQ_STAT: begin
               next_st.bresp = acs_pkg::ACS_RESP_OKAY;   // read-only, ignored
            end
            default: next_st.bresp = acs_pkg::ACS_RESP_SLVERR;
         endcase
         if (!wr_ok) begin
            next_st.bresp = acs_pkg::ACS_RESP_SLVERR;
         end
      end

      // read answers the cycle after the address is taken
      if (st.rvalid && axi_req.rready) begin
         next_st.rvalid = 1'b0;
      end
      if (axi_rsp.arready && axi_req.arvalid) begin
         next_st.rvalid = 1'b1;
         next_st.rdata = rd_word;
         next_st.rresp = rd_ok ? acs_pkg::ACS_RESP_OKAY
                               : acs_pkg::ACS_RESP_SLVERR;
      end

      // start falling edge launches only when powered
      next_st.start_q = st.start;
      launch = st.start_q && !st.start && st.power;

      if (tick) begin
         next_st.tick_cnt = 5'(st.tick_cnt + 5'h01);
      end
      case (st.state)
         acs_pkg::ACS_IDLE: begin
            if (launch) begin
               next_st.state = acs_pkg::ACS_SAMPLE;
               next_st.busy = 1'b1;
               next_st.samp_cnt = 2'h0;
               next_st.tick_cnt = 5'h00;
            end
         end
         acs_pkg::ACS_SAMPLE: begin
            if (tick) begin
               next_st.samp_cnt = 2'(st.samp_cnt + 2'h1);
               if (st.samp_cnt == acs_pkg::ACS_SAMPLE_LAST) begin
                  next_st.state = acs_pkg::ACS_CONVERT;
                  next_st.bit_idx = acs_pkg::ACS_CONV_FIRST;
                  next_st.trial = acs_pkg::ACS_MSB_TRIAL;
               end
            end
         end
         acs_pkg::ACS_CONVERT: begin
            if (tick) begin
               // one bit per period, msb first, twelve periods
               next_st.trial = decided | (bit_mask >> 1);
               next_st.bit_idx = 4'(st.bit_idx - 4'h1);
               if (st.bit_idx == 4'h0) begin
                  done = 1'b1;
                  next_st.result = decided;
                  next_st.trial = 12'h000;
                  next_st.state = acs_pkg::ACS_IDLE;
                  next_st.busy = 1'b0;
               end
            end
         end
         default: next_st.state = acs_pkg::ACS_IDLE;
      endcase

      // start held high or power removed abandons any run
      if (st.start || !st.power) begin
         next_st.state = acs_pkg::ACS_IDLE;
         next_st.busy = 1'b0;
         next_st.trial = 12'h000;
         done = 1'b0;
         next_st.result = st.result;
      end

      // completion flag: a new completion beats a same-cycle clear
      if (done_clr) begin
         next_st.irq_status = 1'b0;
      end
      if (done) begin
         next_st.irq_status = 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
         st.state <= acs_pkg::ACS_IDLE;
         st.div_sel <= acs_pkg::ACS_RST_DIV_SEL;
         st.result <= acs_pkg::ACS_RST_RESULT;
      end else begin
         st <= next_st;
      end
   end

   // bus readiness never depends on the sequencer, so software runs freely
   always_comb begin
      axi_rsp.awready = !st.aw_got && !st.bvalid;
      axi_rsp.wready = !st.w_got && !st.bvalid;
      axi_rsp.bvalid = st.bvalid;
      axi_rsp.bresp = st.bresp;
      axi_rsp.arready = !st.rvalid;
      axi_rsp.rvalid = st.rvalid;
      axi_rsp.rdata = st.rdata;
      axi_rsp.rresp = st.rresp;
   end

   // analog side and interrupt outputs
   always_comb begin
      ana.power_on = st.power;
      ana.sample_hold = (st.state == acs_pkg::ACS_SAMPLE);
      ana.convert = (st.state == acs_pkg::ACS_CONVERT);
      ana.trial = st.trial;
      irq = st.irq_status && st.irq_enable;
   end

   property p_launch_busy;
      @(posedge clk_sys) disable iff (!rst_n)
      ($fell(st.start) && st.power) |=> st.busy;
   endproperty
   a_launch_busy: assert property (p_launch_busy)
      else $error("busy not set after start pulse");

   property p_done_idle;
      @(posedge clk_sys) disable iff (!rst_n)
      done |=> (!st.busy && ana.trial == 12'h000);
   endproperty
   a_done_idle: assert property (p_done_idle)
      else $error("busy still set after completion");

   property p_done_flag;
      @(posedge clk_sys) disable iff (!rst_n)
      (done && st.irq_enable) |=> (st.irq_status && irq);
   endproperty
   a_done_flag: assert property (p_done_flag)
      else $error("completion did not raise interrupt");

   property p_div_four;
      @(posedge clk_sys) disable iff (!rst_n)
      (tick && st.div_sel == 3'h2 && st.busy && !st.start)
         |=> (!tick [*3] ##1 tick) or ##[1:4] !st.busy;
   endproperty
   a_div_four: assert property (p_div_four)
      else $error("conversion clock period wrong for divide by four");

   property p_sample_len;
      @(posedge clk_sys) disable iff (!rst_n)
      (st.busy && $fell(ana.sample_hold)) |-> (st.tick_cnt == 5'h04);
   endproperty
   a_sample_len: assert property (p_sample_len)
      else $error("sampling phase not four periods");

   property p_total_len;
      @(posedge clk_sys) disable iff (!rst_n)
      done |-> (st.tick_cnt == acs_pkg::ACS_TOTAL_LAST);
   endproperty
   a_total_len: assert property (p_total_len)
      else $error("conversion not sixteen periods");

   property p_start_holds;
      @(posedge clk_sys) disable iff (!rst_n)
      (st.start || !st.power) |=> (!st.busy && !ana.sample_hold);
   endproperty
   a_start_holds: assert property (p_start_holds)
      else $error("sequencer ran while start high or unpowered");

   property p_no_power;
      @(posedge clk_sys) disable iff (!rst_n)
      ($fell(st.start) && !st.power) |=> !st.busy [*2];
   endproperty
   a_no_power: assert property (p_no_power)
      else $error("unpowered start launched a conversion");

   property p_result_kept;
      @(posedge clk_sys) disable iff (!rst_n)
      done |=> (st.result == $past(decided));
   endproperty
   a_result_kept: assert property (p_result_kept)
      else $error("result not stored at completion");

   property p_bus_free;
      @(posedge clk_sys) disable iff (!rst_n)
      (st.busy && axi_req.arvalid && axi_rsp.arready) |=> st.rvalid;
   endproperty
   a_bus_free: assert property (p_bus_free)
      else $error("register read stalled by conversion");

   c_full_run: cover property (@(posedge clk_sys) disable iff (!rst_n)
      done);
   c_full_scale: cover property (@(posedge clk_sys) disable iff (!rst_n)
      done && decided == 12'hFFF);
   c_abort: cover property (@(posedge clk_sys) disable iff (!rst_n)
      st.busy && !st.power);

endmodule : acs_seq

// ### sim/acs_ana_model.sv
// behavioural analog core: 12-bit comparator on the live vin, no sample-and-hold.
// assumes the sequencer drives ana from registers and samples cmp_in
// through its own synchroniser.
`timescale 1ns/1ps

module acs_ana_model (
   input wire logic clk_sys,
   input wire acs_pkg::acs_ana_s ana,
   input wire logic [11:0] vin,
   output logic cmp_in
);
   logic toggle = 1'b0;

   // an unpowered or idle core gives no valid answer, so show a changing
   // level rather than a stale one
   always @(posedge clk_sys) begin
      toggle <= ~toggle;
   end

   // compare only while powered and converting
   always_comb begin
      if (ana.power_on && ana.convert) begin
         cmp_in = (vin >= ana.trial);
      end else begin
         cmp_in = toggle;
      end
   end
endmodule : acs_ana_model

// ### sim/tb_top.sv
// bench for the conversion sequencer: AXI4-Lite master tasks, analog
// model, timing counters and a reference result per conversion at divide-by-8 or slower.
// assumes the register map and lengths of acs_pkg.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin \
   num_errors++; $display("ERROR %s expected %0h seen %0h", nm, ex, got); \
   end end

module tb_top;
   localparam logic [31:0] A_C0 = {27'h0, acs_pkg::ACS_OFF_CTRL0};
   localparam logic [31:0] A_C1 = {27'h0, acs_pkg::ACS_OFF_CTRL1};
   localparam logic [31:0] A_HI = {27'h0, acs_pkg::ACS_OFF_RES_HI};
   localparam logic [31:0] A_LO = {27'h0, acs_pkg::ACS_OFF_RES_LO};
   localparam logic [31:0] A_ST = {27'h0, acs_pkg::ACS_OFF_IRQ_STAT};
   localparam logic [31:0] A_CL = {27'h0, acs_pkg::ACS_OFF_IRQ_CLR};
   localparam logic [31:0] A_EN = {27'h0, acs_pkg::ACS_OFF_IRQ_EN};
   localparam logic [1:0] OK = acs_pkg::ACS_RESP_OKAY;
   localparam logic [1:0] ERR = acs_pkg::ACS_RESP_SLVERR;
   // analog settling wait after power-up, a bench choice
   localparam int SETTLE_CYC = 40;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   acs_pkg::acs_axi_req_s req = '0;
   acs_pkg::acs_axi_rsp_s rsp;
   acs_pkg::acs_ana_s ana;
   logic cmp_in;
   logic irq;
   logic [11:0] vin = 12'h000;
   logic [11:0] exp_res = 12'h000;
   logic [31:0] seed = 32'h1CD1;
   logic [31:0] rst_addr [6] = '{A_C0, A_C1, A_HI, A_LO, A_ST, A_EN};
   logic [31:0] d;
   int num_errors = 0;
   int num_checks = 0;
   int n_samp = 0;
   int n_conv = 0;

   always #20 clk_sys = ~clk_sys;

   acs_seq i_acs_seq (.clk_sys(clk_sys), .rst_n(rst_n), .axi_req(req),
      .axi_rsp(rsp), .cmp_in(cmp_in), .ana(ana), .irq(irq));
   acs_ana_model i_acs_ana_model (.clk_sys(clk_sys), .ana(ana), .vin(vin),
      .cmp_in(cmp_in));

   // phase lengths measured in system clocks
   always @(posedge clk_sys) begin
      if (ana.sample_hold === 1'b1) n_samp++;
      if (ana.convert === 1'b1) n_conv++;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic give_verdict;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : give_verdict

   // write: address and data offered together, each dropped once taken
   task automatic wr(input logic [31:0] a, input logic [31:0] v,
                     input logic [1:0] er);
      @(posedge clk_sys);
      req.awvalid <= 1'b1;
      req.awaddr <= a;
      req.wvalid <= 1'b1;
      req.wdata <= v;
      req.wstrb <= 4'hF;
      req.bready <= 1'b1;
      // this wait ends once bvalid is seen, or at the watchdog if it never is
      do begin
         @(posedge clk_sys);
         if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
         if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
      end while (rsp.bvalid !== 1'b1);
      req.bready <= 1'b0;
      `CHK("bresp", er, rsp.bresp)
   endtask : wr

   task automatic rd(input logic [31:0] a, output logic [31:0] v,
                     input logic [1:0] er);
      @(posedge clk_sys);
      req.arvalid <= 1'b1;
      req.araddr <= a;
      req.rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
      end while (rsp.rvalid !== 1'b1);
      v = rsp.rdata;
      req.rready <= 1'b0;
      `CHK("rresp", er, rsp.rresp)
   endtask : rd

   // one full conversion, polled on busy, result checked against vin for sel 3 and up
   task automatic run_conv(input int sel, input logic [11:0] v,
                           input logic ien);
      logic [31:0] r;
      int n;
      wr(A_C1, sel, OK);
      wr(A_EN, {31'h0, ien}, OK);
      vin <= v;
      wr(A_C0, 32'h3, OK);
      n_samp = 0;
      n_conv = 0;
      wr(A_C0, 32'h2, OK);
      n = 0;
      do begin
         rd(A_C0, r, OK);
         if (n == 0 && sel >= 2) `CHK("busy set", 1'b1, r[7])
         n++;
      end while (r[7] !== 1'b0 && n < 2000);
      `CHK("busy clear", 1'b0, r[7])
      `CHK("sample len", 4 << sel, n_samp)
      `CHK("conv len", 12 << sel, n_conv)
      // below divide-by-8 the comparator path cannot settle per bit
      if (sel >= 3) exp_res = v;
      rd(A_HI, r, OK);
      if (sel >= 3) `CHK("res hi", {28'h0, exp_res[11:8]}, r)
      rd(A_LO, r, OK);
      if (sel >= 3) `CHK("res lo", {24'h0, exp_res[7:0]}, r)
      rd(A_ST, r, OK);
      `CHK("irq stat", 32'h1, r)
      `CHK("irq out", ien, irq)
      wr(A_CL, 32'h1, OK);
      `CHK("irq cleared", 1'b0, irq)
      $display("test conversion sel %0d done", sel);
   endtask : run_conv

   initial begin
      repeat (40000) @(posedge clk_sys);
      num_errors++;
      give_verdict();
   end

   initial begin
      repeat (5) @(posedge clk_sys);
      rst_n <= 1'b1;
      // reset values and unmapped or read-only places
      foreach (rst_addr[i]) begin
         rd(rst_addr[i], d, OK);
         `CHK("reset value", 32'h0, d)
      end
      rd(32'h1C, d, ERR);
      `CHK("unmapped data", 32'h0, d)
      wr(32'h1C, 32'h1, ERR);
      rd(32'h2, d, ERR);
      wr(A_LO, 32'hFF, OK);
      rd(A_LO, d, OK);
      `CHK("read only", 32'h0, d)
      $display("test registers done");
      // start pulse with power off
      wr(A_C0, 32'h1, OK);
      wr(A_C0, 32'h0, OK);
      repeat (20) @(posedge clk_sys);
      rd(A_C0, d, OK);
      `CHK("no launch", 32'h0, d)
      `CHK("power off", 1'b0, ana.power_on)
      wr(A_C0, 32'h2, OK);
      `CHK("power on", 1'b1, ana.power_on)
      repeat (SETTLE_CYC) @(posedge clk_sys);
      $display("test power gate done");
      // every divider code, one run with the interrupt masked
      for (int s = 0; s < 8; s++) begin
         seed = lfsr(seed);
         run_conv(s, (s == 3) ? 12'hFFF : (s == 4) ? 12'h000 : seed[11:0],
                  s != 5);
      end
      // start high in mid-run aborts, the falling edge relaunches
      wr(A_C0, 32'h3, OK);
      wr(A_C0, 32'h2, OK);
      repeat (100) @(posedge clk_sys);
      wr(A_C0, 32'h3, OK);
      rd(A_C0, d, OK);
      `CHK("abort busy", 1'b0, d[7])
      seed = lfsr(seed);
      run_conv(7, seed[11:0], 1'b1);
      // power dropped in mid-run aborts, result kept, no request
      wr(A_C0, 32'h3, OK);
      wr(A_C0, 32'h2, OK);
      repeat (100) @(posedge clk_sys);
      wr(A_C0, 32'h0, OK);
      rd(A_C0, d, OK);
      `CHK("power abort", 32'h0, d)
      rd(A_ST, d, OK);
      `CHK("no request", 32'h0, d)
      rd(A_LO, d, OK);
      `CHK("result kept", {24'h0, exp_res[7:0]}, d)
      $display("test aborts done");
      give_verdict();
   end
endmodule : tb_top
